//--- core/swa_aggregator.v
`include "swa_map.vh"

////////////////////////////////////////////////////////////////////////////////
module swa_aggregator #(
  parameter MS_CYCLES = `SWA_MS_CYCLES
) (
  input  wire        core_clk_i,
  input  wire        reset_n_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_write_i,
  input  wire        reg_read_i,
  output reg  [31:0] reg_rdata_o,
  input  wire        alarm_clear_input_i,
  input  wire [7:0]  load_factor_i,
  input  wire [7:0]  regen_factor_i,
  input  wire [7:0]  battery_voltage_i,
  input  wire        fan_stopped_i,
  input  wire [7:0]  enc_err_run_i,
  input  wire        enc_overheat_i,
  input  wire        enc_inc_20bit_i,
  input  wire [9:0]  torque_osc_i,
  input  wire        life_short_i,
  input  wire        main_power_lost_i,
  input  wire [15:0] motor_speed_i,
  input  wire        position_control_i,
  input  wire [31:0] position_cmd_i,
  input  wire [31:0] position_act_i,
  input  wire [15:0] motor_revs_i,
  input  wire [15:0] torque_cmd_i,
  input  wire [15:0] torque_limit_ext_i,
  output reg         warning_out_first_o,
  output reg         warning_out_second_o,
  output reg         torque_in_limit_out_o,
  output reg  [15:0] torque_limit_o,
  output reg         err_overspeed_o,
  output reg         err_pos_dev_o,
  output reg         err_soft_limit_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // configuration registers

  reg  [3:0]  warn_out_first_select;
  reg  [3:0]  warn_out_second_select;
  reg  [15:0] warning_mask_setting;
  reg  [9:0]  oscillation_detect_level;
  reg  [10:0] main_power_off_detect_time;
  reg  [15:0] overspeed_level_setting;
  reg  [31:0] position_deviation_limit;
  reg  [15:0] motor_working_range;
  reg  [3:0]  torque_limit_selection;
  reg  [15:0] first_torque_limit;
  reg         warning_latch_select;
  reg  [7:0]  enc_err_limit;
  reg         sw_clear;
  reg         clr_meta;
  reg         clr_sync;
  reg  [17:0] ms_count;
  reg         ms_tick;
  reg  [9:0]  fan_ms;
  reg         fan_long;
  reg  [10:0] mpoff_ms;
  reg         mpoff_long;
  wire [14:0] warn;
  reg  [15:0] raw;
  wire        clear_all;
  wire        any_warn;
  reg  [31:0] next_rdata;
  wire [15:0] speed_abs;
  wire [31:0] pos_diff;
  wire [31:0] pos_diff_abs;
  wire [15:0] revs_abs;
  wire [15:0] torque_abs;
  wire [15:0] next_limit;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function [3:0] mask_pos;
    input [3:0] sel;
    begin
      case (sel)
        `SWA_SEL_OVERLOAD:   mask_pos = `SWA_MBIT_OVERLOAD;
        `SWA_SEL_OVER_REGEN: mask_pos = `SWA_MBIT_OVER_REGEN;
        `SWA_SEL_BATTERY:    mask_pos = `SWA_MBIT_BATTERY;
        `SWA_SEL_FAN:        mask_pos = `SWA_MBIT_FAN;
        `SWA_SEL_ENC_COMM:   mask_pos = `SWA_MBIT_ENC_COMM;
        `SWA_SEL_ENC_HEAT:   mask_pos = `SWA_MBIT_ENC_HEAT;
        `SWA_SEL_OSC:        mask_pos = `SWA_MBIT_OSC;
        `SWA_SEL_LIFETIME:   mask_pos = `SWA_MBIT_LIFETIME;
        `SWA_SEL_EXT_SCALE:  mask_pos = `SWA_MBIT_EXT_SCALE;
        `SWA_SEL_EXT_COMM:   mask_pos = `SWA_MBIT_EXT_COMM;
        `SWA_SEL_MAIN_POWER: mask_pos = `SWA_MBIT_MAIN_POWER;
        default:             mask_pos = 4'hF;
      endcase
    end
  endfunction

  // listed selection values only; anything else reads as no warning
  function pick_warn;
    input [3:0]  sel;
    input [14:0] vec;
    begin
      case (sel)
        `SWA_SEL_ALL:        pick_warn = |vec;
        `SWA_SEL_OVERLOAD,
        `SWA_SEL_OVER_REGEN,
        `SWA_SEL_BATTERY,
        `SWA_SEL_FAN,
        `SWA_SEL_ENC_COMM,
        `SWA_SEL_ENC_HEAT,
        `SWA_SEL_OSC,
        `SWA_SEL_LIFETIME,
        `SWA_SEL_EXT_SCALE,
        `SWA_SEL_EXT_COMM,
        `SWA_SEL_MAIN_POWER: pick_warn = vec[sel];
        default:             pick_warn = 1'b0;
      endcase
    end
  endfunction

  function [15:0] abs16;
    input [15:0] v;
    begin
      abs16 = v[15] ? (~v + 16'h0001) : v;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // register bus

  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      warn_out_first_select      <= `SWA_RST_SEL;
      warn_out_second_select     <= `SWA_RST_SEL;
      warning_mask_setting       <= `SWA_RST_MASK;
      oscillation_detect_level   <= `SWA_RST_OSC_LEVEL;
      main_power_off_detect_time <= `SWA_RST_MPOFF_TIME;
      overspeed_level_setting    <= `SWA_RST_OVERSPEED;
      position_deviation_limit   <= `SWA_RST_DEV_LIMIT;
      motor_working_range        <= `SWA_RST_WORK_RANGE;
      torque_limit_selection     <= `SWA_RST_TQ_SEL;
      first_torque_limit         <= `SWA_RST_TQ_LIMIT1;
      warning_latch_select       <= `SWA_RST_LATCH_SEL;
      enc_err_limit              <= `SWA_RST_ENC_ERR_LIMIT;
      sw_clear                   <= 1'b0;
    end else begin
      sw_clear <= 1'b0;
      if (reg_write_i) begin
        case (reg_addr_i)
          `SWA_OFS_SEL_FIRST:     warn_out_first_select      <= reg_wdata_i[3:0];
          `SWA_OFS_SEL_SECOND:    warn_out_second_select     <= reg_wdata_i[3:0];
          `SWA_OFS_WARN_MASK:     warning_mask_setting       <= reg_wdata_i[15:0];
          `SWA_OFS_OSC_LEVEL:     oscillation_detect_level   <= reg_wdata_i[9:0];
          `SWA_OFS_MPOFF_TIME:    main_power_off_detect_time <= reg_wdata_i[10:0];
          `SWA_OFS_OVERSPEED:     overspeed_level_setting    <= reg_wdata_i[15:0];
          `SWA_OFS_DEV_LIMIT:     position_deviation_limit   <= reg_wdata_i;
          `SWA_OFS_WORK_RANGE:    motor_working_range        <= reg_wdata_i[15:0];
          `SWA_OFS_TQ_SEL:        torque_limit_selection     <= reg_wdata_i[3:0];
          `SWA_OFS_TQ_LIMIT1:     first_torque_limit         <= reg_wdata_i[15:0];
          `SWA_OFS_LATCH_SEL:     warning_latch_select       <= reg_wdata_i[0];
          `SWA_OFS_ENC_ERR_LIMIT: enc_err_limit              <= reg_wdata_i[7:0];
          `SWA_OFS_CTRL:          sw_clear <= reg_wdata_i[`SWA_CTRL_CLEAR_BIT];
          default:                sw_clear <= 1'b0;
        endcase
      end
    end
  end

  always @* begin
    next_rdata = 32'h0000_0000;
    if (reg_read_i) begin
      case (reg_addr_i)
        `SWA_OFS_SEL_FIRST:     next_rdata = {28'h0000000, warn_out_first_select};
        `SWA_OFS_SEL_SECOND:    next_rdata = {28'h0000000, warn_out_second_select};
        `SWA_OFS_WARN_MASK:     next_rdata = {16'h0000, warning_mask_setting};
        `SWA_OFS_OSC_LEVEL:     next_rdata = {22'h000000, oscillation_detect_level};
        `SWA_OFS_MPOFF_TIME:    next_rdata = {21'h000000, main_power_off_detect_time};
        `SWA_OFS_OVERSPEED:     next_rdata = {16'h0000, overspeed_level_setting};
        `SWA_OFS_DEV_LIMIT:     next_rdata = position_deviation_limit;
        `SWA_OFS_WORK_RANGE:    next_rdata = {16'h0000, motor_working_range};
        `SWA_OFS_TQ_SEL:        next_rdata = {28'h0000000, torque_limit_selection};
        `SWA_OFS_TQ_LIMIT1:     next_rdata = {16'h0000, first_torque_limit};
        `SWA_OFS_LATCH_SEL:     next_rdata = {31'h00000000, warning_latch_select};
        `SWA_OFS_ENC_ERR_LIMIT: next_rdata = {24'h000000, enc_err_limit};
        `SWA_OFS_WARN_STATUS:   next_rdata = {17'h00000, warn};
        `SWA_OFS_ERR_STATUS:
          next_rdata = {29'h00000000, err_soft_limit_o, err_pos_dev_o, err_overspeed_o};
        default:                next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // clear input synchroniser and millisecond tick

  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clr_meta <= 1'b0;
      clr_sync <= 1'b0;
      ms_count <= 18'h00000;
      ms_tick  <= 1'b0;
    end else begin
      clr_meta <= alarm_clear_input_i;
      clr_sync <= clr_meta;
      if (ms_count == MS_CYCLES[17:0] - 18'h00001) begin
        ms_count <= 18'h00000;
        ms_tick  <= 1'b1;
      end else begin
        ms_count <= ms_count + 18'h00001;
        ms_tick  <= 1'b0;
      end
    end
  end

  assign clear_all = sw_clear | clr_sync;

  ////////////////////////////////////////////////////////////////////////////////
  // persistence timers

  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fan_ms     <= 10'h000;
      fan_long   <= 1'b0;
      mpoff_ms   <= 11'h000;
      mpoff_long <= 1'b0;
    end else begin
      if (!fan_stopped_i) begin
        fan_ms   <= 10'h000;
        fan_long <= 1'b0;
      end else if (ms_tick && !fan_long) begin
        if (fan_ms == (`SWA_FAN_SEC_MS - 1)) begin
          fan_long <= 1'b1;
        end else begin
          fan_ms <= fan_ms + 10'h001;
        end
      end
      if (!main_power_lost_i) begin
        mpoff_ms   <= 11'h000;
        mpoff_long <= 1'b0;
      end else if (ms_tick && !mpoff_long) begin
        if (mpoff_ms >= main_power_off_detect_time) begin
          mpoff_long <= 1'b1;
        end else begin
          mpoff_ms <= mpoff_ms + 11'h001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // warning causes, indexed by selection value

  always @* begin
    raw = 16'h0000;
    raw[`SWA_SEL_OVERLOAD]   = load_factor_i >= `SWA_LOAD_WARN_PCT;
    raw[`SWA_SEL_OVER_REGEN] = regen_factor_i >= `SWA_LOAD_WARN_PCT;
    raw[`SWA_SEL_BATTERY]    = battery_voltage_i <= `SWA_BATT_LOW_DV;
    raw[`SWA_SEL_FAN]        = fan_long;
    raw[`SWA_SEL_ENC_COMM]   = enc_err_run_i > enc_err_limit;
    raw[`SWA_SEL_ENC_HEAT]   = enc_overheat_i & enc_inc_20bit_i;
    raw[`SWA_SEL_OSC]        = (oscillation_detect_level != 10'h000) &&
                               (torque_osc_i > oscillation_detect_level);
    raw[`SWA_SEL_LIFETIME]   = life_short_i;
    raw[`SWA_SEL_EXT_SCALE]  = 1'b0;
    raw[`SWA_SEL_EXT_COMM]   = 1'b0;
    raw[`SWA_SEL_MAIN_POWER] = mpoff_long &&
                               (main_power_off_detect_time >= `SWA_MPOFF_MIN_MS) &&
                               (main_power_off_detect_time <= `SWA_MPOFF_MAX_MS);
  end

  assign warn[0] = 1'b0;

  genvar gi;
  generate
    for (gi = 1; gi < 15; gi = gi + 1) begin : g_warn
      localparam [31:0] SEL_IDX = gi;
      wire       masked;
      wire [3:0] sel_v = SEL_IDX[3:0];
      assign masked = (mask_pos(sel_v) != 4'hF) &&
                      warning_mask_setting[mask_pos(sel_v)];
      swa_warn_cell u_cell (
        .core_clk_i   (core_clk_i),
        .reset_n_i    (reset_n_i),
        .cause_i      (raw[gi] & ~masked),
        .latch_mode_i (warning_latch_select),
        .clear_i      (clear_all),
        .ms_tick_i    (ms_tick),
        .flag_o       (warn[gi])
      );
    end
  endgenerate

  assign any_warn = |warn;

  ////////////////////////////////////////////////////////////////////////////////
  // protection errors and torque limit

  assign speed_abs    = abs16(motor_speed_i);
  assign pos_diff     = position_cmd_i - position_act_i;
  assign pos_diff_abs = pos_diff[31] ? (~pos_diff + 32'h0000_0001) : pos_diff;
  assign revs_abs     = abs16(motor_revs_i);
  assign torque_abs   = abs16(torque_cmd_i);
  assign next_limit   = (torque_limit_selection <= 4'h1) ?
                        first_torque_limit : torque_limit_ext_i;

  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      warning_out_first_o   <= 1'b0;
      warning_out_second_o  <= 1'b0;
      torque_in_limit_out_o <= 1'b0;
      torque_limit_o        <= `SWA_RST_TQ_LIMIT1;
      err_overspeed_o       <= 1'b0;
      err_pos_dev_o         <= 1'b0;
      err_soft_limit_o      <= 1'b0;
    end else begin
      warning_out_first_o   <= pick_warn(warn_out_first_select, warn);
      warning_out_second_o  <= pick_warn(warn_out_second_select, warn);
      torque_limit_o        <= next_limit;
      torque_in_limit_out_o <= torque_abs >= next_limit;
      if (speed_abs > overspeed_level_setting) begin
        err_overspeed_o <= 1'b1;
      end else if (clear_all) begin
        err_overspeed_o <= 1'b0;
      end
      if (position_control_i && (pos_diff_abs > position_deviation_limit)) begin
        err_pos_dev_o <= 1'b1;
      end else if (clear_all) begin
        err_pos_dev_o <= 1'b0;
      end
      if (position_control_i && (revs_abs > motor_working_range)) begin
        err_soft_limit_o <= 1'b1;
      end else if (clear_all) begin
        err_soft_limit_o <= 1'b0;
      end
    end
  end

endmodule

//--- core/swa_map.vh
`ifndef SWA_MAP_VH
`define SWA_MAP_VH

// register byte offsets
`define SWA_OFS_SEL_FIRST      8'h00
`define SWA_OFS_SEL_SECOND     8'h04
`define SWA_OFS_WARN_MASK      8'h08
`define SWA_OFS_OSC_LEVEL      8'h0C
`define SWA_OFS_MPOFF_TIME     8'h10
`define SWA_OFS_OVERSPEED      8'h14
`define SWA_OFS_DEV_LIMIT      8'h18
`define SWA_OFS_WORK_RANGE     8'h1C
`define SWA_OFS_TQ_SEL         8'h20
`define SWA_OFS_TQ_LIMIT1      8'h24
`define SWA_OFS_LATCH_SEL      8'h28
`define SWA_OFS_ENC_ERR_LIMIT  8'h2C
`define SWA_OFS_CTRL           8'h30
`define SWA_OFS_WARN_STATUS    8'h34
`define SWA_OFS_ERR_STATUS     8'h38

// field positions
`define SWA_CTRL_CLEAR_BIT     0
`define SWA_ERR_OVERSPEED_BIT  0
`define SWA_ERR_POS_DEV_BIT    1
`define SWA_ERR_SOFT_LIM_BIT   2

// warning selection values
`define SWA_SEL_ALL            4'h0
`define SWA_SEL_OVERLOAD       4'h1
`define SWA_SEL_OVER_REGEN     4'h2
`define SWA_SEL_BATTERY        4'h3
`define SWA_SEL_FAN            4'h4
`define SWA_SEL_ENC_COMM       4'h5
`define SWA_SEL_ENC_HEAT       4'h6
`define SWA_SEL_OSC            4'h7
`define SWA_SEL_LIFETIME       4'h8
`define SWA_SEL_EXT_SCALE      4'h9
`define SWA_SEL_EXT_COMM       4'hA
`define SWA_SEL_MAIN_POWER     4'hE

// mask bit positions
`define SWA_MBIT_OVERLOAD      7
`define SWA_MBIT_OVER_REGEN    5
`define SWA_MBIT_BATTERY       0
`define SWA_MBIT_FAN           6
`define SWA_MBIT_ENC_COMM      4
`define SWA_MBIT_ENC_HEAT      3
`define SWA_MBIT_OSC           13
`define SWA_MBIT_LIFETIME      2
`define SWA_MBIT_EXT_SCALE     8
`define SWA_MBIT_EXT_COMM      14
`define SWA_MBIT_MAIN_POWER    12

// thresholds
`define SWA_LOAD_WARN_PCT      8'h55
`define SWA_BATT_LOW_DV        8'h20
`define SWA_MPOFF_MIN_MS       11'h00A
`define SWA_MPOFF_MAX_MS       11'h7CF

// reset values
`define SWA_RST_SEL            4'h0
`define SWA_RST_MASK           16'h0000
`define SWA_RST_OSC_LEVEL      10'h000
`define SWA_RST_MPOFF_TIME     11'h046
`define SWA_RST_MOTOR_MAX_RPM  16'h1770
`define SWA_RST_OVERSPEED      16'h1C20
`define SWA_RST_DEV_LIMIT      32'h0000_7530
`define SWA_RST_WORK_RANGE     16'h000A
`define SWA_RST_TQ_SEL         4'h1
`define SWA_RST_TQ_LIMIT1      16'h01F4
`define SWA_RST_LATCH_SEL      1'h0
`define SWA_RST_ENC_ERR_LIMIT  8'h03

// timing
`define SWA_CLK_MHZ            250
`define SWA_MS_NS              1000000
`define SWA_CLK_NS             4
`define SWA_MS_CYCLES          (`SWA_MS_NS / `SWA_CLK_NS)
`define SWA_HOLD_SEC_MS        1000
`define SWA_FAN_SEC_MS         1000

`endif

//--- core/swa_warn_cell.v
`include "swa_map.vh"

// one warning flag: set by its cause, held 1 s or latched, cleared by alarm clear
module swa_warn_cell (
  input  wire core_clk_i,
  input  wire reset_n_i,
  input  wire cause_i,
  input  wire latch_mode_i,
  input  wire clear_i,
  input  wire ms_tick_i,
  output reg  flag_o
);

  reg [9:0] hold_ms;

  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_o  <= 1'b0;
      hold_ms <= 10'h000;
    end else if (clear_i) begin
      flag_o  <= 1'b0;
      hold_ms <= 10'h000;
    end else if (cause_i) begin
      flag_o  <= 1'b1;
      hold_ms <= 10'h000;
    end else if (flag_o && !latch_mode_i && ms_tick_i) begin
      if (hold_ms == (`SWA_HOLD_SEC_MS - 1)) begin
        flag_o  <= 1'b0;
        hold_ms <= 10'h000;
      end else begin
        hold_ms <= hold_ms + 10'h001;
      end
    end
  end

endmodule

//--- tb/swa_aggregator_props.sv
`include "swa_map.vh"

module swa_aggregator_props #(
  parameter MS_CYCLES = 4
) (
  input wire        core_clk_i,
  input wire        reset_n_i,
  input wire [7:0]  reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire        reg_write_i,
  input wire        reg_read_i,
  input wire [31:0] reg_rdata_o,
  input wire        alarm_clear_input_i,
  input wire [7:0]  load_factor_i,
  input wire [15:0] motor_speed_i,
  input wire        position_control_i,
  input wire        warning_out_first_o,
  input wire        warning_out_second_o,
  input wire        err_overspeed_o,
  input wire        err_pos_dev_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  reg  [3:0]  sel1;
  reg  [15:0] mask;
  reg  [15:0] lvl;
  reg  [3:0]  age;
  wire        wr = reg_write_i;
  ////////////////////////////////////////
  // shadow settings; age counts cycles since a clear request
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sel1 <= 4'h0;
      mask <= 16'h0000;
      lvl <= `SWA_RST_OVERSPEED;
      age <= 4'hF;
    end else begin
      if (wr && reg_addr_i == `SWA_OFS_SEL_FIRST)
        sel1 <= reg_wdata_i[3:0];
      if (wr && reg_addr_i == `SWA_OFS_WARN_MASK)
        mask <= reg_wdata_i[15:0];
      if (wr && reg_addr_i == `SWA_OFS_OVERSPEED)
        lvl <= reg_wdata_i[15:0];
      if (alarm_clear_input_i || (wr && reg_addr_i == `SWA_OFS_CTRL && reg_wdata_i[0]))
        age <= 4'h0;
      else if (age != 4'hF)
        age <= age + 4'h1;
    end
  end
  ////////////////////////////////////////
  AST_RESET_QUIET: assert property (
    $rose(reset_n_i) |-> !warning_out_first_o && !warning_out_second_o)
    else $error("warning output active after reset");
  AST_RDATA_IDLE: assert property (
    !$past(reg_read_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside read cycle");
  AST_OVERLOAD_FIRST: assert property (
    (load_factor_i >= `SWA_LOAD_WARN_PCT && !mask[`SWA_MBIT_OVERLOAD] && sel1 <= 4'h1
     && age > 4'h4) [*3] |-> warning_out_first_o)
    else $error("overload warning missing");
  AST_FIRST_SILENT: assert property (
    (sel1 >= 4'h9 && sel1 != 4'hE) [*2] |-> !warning_out_first_o)
    else $error("reserved selection drives output");
  AST_PIN_HELD: assert property (
    alarm_clear_input_i [*5] |=> !warning_out_first_o && !warning_out_second_o)
    else $error("warning while clear pin held");
  AST_OVERSPEED_SET: assert property (
    (!motor_speed_i[15] && motor_speed_i > lvl) |=> err_overspeed_o)
    else $error("overspeed error missing");
  AST_ERR_CLEAR: assert property (
    $fell(err_overspeed_o) |-> age < 4'h6)
    else $error("overspeed error dropped without clear");
  AST_DEV_IN_POSITION: assert property (
    $rose(err_pos_dev_o) |-> $past(position_control_i))
    else $error("deviation error outside position control");
  cover property (warning_out_first_o && warning_out_second_o);
  cover property ($rose(err_overspeed_o));
  cover property ($fell(warning_out_first_o) && age < 4'h4);
endmodule

bind swa_aggregator swa_aggregator_props #(.MS_CYCLES(MS_CYCLES)) u_props (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
  .reg_rdata_o(reg_rdata_o), .alarm_clear_input_i(alarm_clear_input_i),
  .load_factor_i(load_factor_i), .motor_speed_i(motor_speed_i),
  .position_control_i(position_control_i), .warning_out_first_o(warning_out_first_o),
  .warning_out_second_o(warning_out_second_o), .err_overspeed_o(err_overspeed_o),
  .err_pos_dev_o(err_pos_dev_o)
);

//--- tb/swa_host_model.sv
module swa_host_model (
  input  wire        core_clk_i,
  input  wire        reset_n_i,
  input  wire        warn_first_i,
  output reg  [15:0] rises_o
);
  timeunit 1ns;
  timeprecision 1ps;
  reg last;
  // host counts each new warning seen on the first output
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last <= 1'b0;
      rises_o <= 16'h0000;
    end else begin
      last <= warn_first_i;
      if (warn_first_i && !last)
        rises_o <= rises_o + 16'h0001;
    end
  end
endmodule

//--- tb/test_swa_aggregator.sv
`include "swa_map.vh"

module test_swa_aggregator;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_i = 1'b0, reset_n_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  logic        reg_write_i = 1'b0, reg_read_i = 1'b0, alarm_clear_input_i = 1'b0;
  logic [7:0]  load_factor_i = 8'h00, regen_factor_i = 8'h00, enc_err_run_i = 8'h00;
  logic [7:0]  battery_voltage_i = 8'h40;
  logic        fan_stopped_i = 1'b0, enc_overheat_i = 1'b0, enc_inc_20bit_i = 1'b0;
  logic        life_short_i = 1'b0, main_power_lost_i = 1'b0, position_control_i = 1'b0;
  logic [9:0]  torque_osc_i = 10'h000;
  logic [15:0] motor_speed_i = 16'h0000, motor_revs_i = 16'h0000, torque_cmd_i = 16'h0000;
  logic [15:0] torque_limit_ext_i = 16'h02BC, torque_limit_o, rises, r0;
  logic [31:0] position_cmd_i = 32'h0, position_act_i = 32'h0;
  logic        warning_out_first_o, warning_out_second_o, torque_in_limit_out_o;
  logic        err_overspeed_o, err_pos_dev_o, err_soft_limit_o;
  int          n_fail = 0, n_tests = 0;
  int          rstv [16] = '{0, 0, 0, 0, 70, 7200, 30000, 10, 1, 500, 0, 3, 0, 0, 0, 0};
  int          sv [9] = '{1, 2, 3, 4, 5, 6, 7, 8, 14};
  int          tlo [9] = '{2, 2, 2, 3990, 2, 2, 2, 2, 276};
  int          thi [9] = '{2, 2, 2, 4012, 2, 2, 2, 2, 292};

  always #2 core_clk_i = ~core_clk_i;
  swa_aggregator #(.MS_CYCLES(4)) dut (.*);
  swa_host_model host (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .warn_first_i(warning_out_first_o), .rises_o(rises));
  ////////////////////////////////////////
  task automatic conclude();
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_write_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_write_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
    @(posedge core_clk_i);
    reg_read_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_read_i <= 1'b0;
    #1 chk(nm, ex, reg_rdata_o);
  endtask
  // drives one warning cause to its firing or just-quiet value
  task automatic cause(input int k, input logic on);
    @(posedge core_clk_i);
    case (k)
      1: load_factor_i <= on ? 8'h55 : 8'h54;
      2: regen_factor_i <= on ? 8'h55 : 8'h54;
      3: battery_voltage_i <= on ? 8'h20 : 8'h21;
      4: fan_stopped_i <= on;
      5: enc_err_run_i <= on ? 8'h04 : 8'h03;
      6: enc_inc_20bit_i <= on;
      7: torque_osc_i <= on ? 10'h065 : 10'h064;
      8: life_short_i <= on;
      default: main_power_lost_i <= on;
    endcase
  endtask
  task automatic wt(input logic v, input int lo, input int hi);
    int n;
    n = 0;
    #1;
    while (warning_out_first_o !== v && n <= hi) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    chk("warning timing", 32'h1, 32'(n >= lo && n <= hi));
    if (n > hi)
      conclude();
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    wr(8'h3C, 32'hFFFF_FFFF);
    wr(`SWA_OFS_WARN_STATUS, 32'h0000_FFFF);
    for (int i = 0; i < 16; i++)
      rd(8'(i * 4), rstv[i], "reset value");
    chk("torque limit", 32'h1F4, 32'(torque_limit_o));
    @(posedge core_clk_i);
    enc_overheat_i <= 1'b1;
    for (int k = 1; k < 10; k++)
      cause(k, 1'b0);
    torque_osc_i <= 10'h3E8;
    cyc(8);
    chk("quiet", 32'h0, 32'({warning_out_first_o, warning_out_second_o}));
    cause(7, 1'b0);
    wr(`SWA_OFS_OSC_LEVEL, 32'h64);
    wr(`SWA_OFS_LATCH_SEL, 32'h1);
    for (int i = 0; i < 9; i++) begin
      wr(`SWA_OFS_SEL_FIRST, sv[i]);
      cause(sv[i], 1'b1);
      wt(1'b1, tlo[i], thi[i]);
      chk("second output", 32'h1, 32'(warning_out_second_o));
      cause(sv[i], 1'b0);
      rd(`SWA_OFS_WARN_STATUS, 32'h1 << sv[i], "latched status");
      wr(`SWA_OFS_CTRL, 32'h1);
      wt(1'b0, 1, 4);
    end
    cause(1, 1'b1);
    for (int s = 2; s < 16; s++) begin
      wr(`SWA_OFS_SEL_FIRST, s);
      wr(`SWA_OFS_SEL_SECOND, s);
      cyc(3);
      chk("selected output", 32'h0, 32'({warning_out_first_o, warning_out_second_o}));
    end
    wr(`SWA_OFS_SEL_FIRST, 32'h1);
    wr(`SWA_OFS_SEL_SECOND, 32'h1);
    cyc(3);
    chk("second select", 32'h1, 32'(warning_out_second_o));
    r0 = rises;
    wr(`SWA_OFS_CTRL, 32'h1);
    cyc(6);
    chk("raise count", 32'(r0 + 16'h1), 32'(rises));
    wr(`SWA_OFS_WARN_MASK, 32'h80);
    wr(`SWA_OFS_CTRL, 32'h1);
    cyc(6);
    chk("masked output", 32'h0, 32'(warning_out_first_o));
    wr(`SWA_OFS_WARN_MASK, 32'h0);
    cyc(3);
    chk("unmasked output", 32'h1, 32'(warning_out_first_o));
    @(posedge core_clk_i);
    alarm_clear_input_i <= 1'b1;
    cyc(30);
    chk("held clear", 32'h0, 32'({warning_out_first_o, warning_out_second_o}));
    @(posedge core_clk_i);
    alarm_clear_input_i <= 1'b0;
    cyc(8);
    chk("after clear pin", 32'h1, 32'(warning_out_first_o));
    wr(`SWA_OFS_LATCH_SEL, 32'h0);
    cause(1, 1'b0);
    cyc(3950);
    chk("hold time", 32'h1, 32'(warning_out_first_o));
    wt(1'b0, 1, 100);
    @(posedge core_clk_i);
    motor_speed_i <= 16'h1C20;
    position_cmd_i <= 32'h7531;
    motor_revs_i <= 16'h000B;
    cyc(4);
    chk("errors idle", 32'h0, 32'({err_soft_limit_o, err_pos_dev_o, err_overspeed_o}));
    @(posedge core_clk_i);
    motor_speed_i <= 16'h1C21;
    position_control_i <= 1'b1;
    cyc(3);
    rd(`SWA_OFS_ERR_STATUS, 32'h7, "error status");
    @(posedge core_clk_i);
    motor_speed_i <= 16'h0000;
    position_control_i <= 1'b0;
    wr(`SWA_OFS_CTRL, 32'h1);
    cyc(3);
    chk("errors cleared", 32'h0, 32'({err_soft_limit_o, err_pos_dev_o, err_overspeed_o}));
    @(posedge core_clk_i);
    torque_cmd_i <= 16'h01F4;
    cyc(3);
    chk("in limit", 32'h1, 32'(torque_in_limit_out_o));
    @(posedge core_clk_i);
    torque_cmd_i <= 16'hFE0D;
    cyc(3);
    chk("below limit", 32'h0, 32'(torque_in_limit_out_o));
    wr(`SWA_OFS_TQ_SEL, 32'h2);
    cyc(3);
    chk("external limit", 32'h2BC, 32'(torque_limit_o));
    wr(`SWA_OFS_TQ_SEL, 32'h0);
    wr(`SWA_OFS_TQ_LIMIT1, 32'h12C);
    cyc(3);
    chk("first limit", 32'h12C, 32'(torque_limit_o));
    wr(`SWA_OFS_SEL_FIRST, 32'hE);
    wr(`SWA_OFS_MPOFF_TIME, 32'h5);
    cause(9, 1'b1);
    cyc(40);
    chk("power warning off range", 32'h0, 32'(warning_out_first_o));
    conclude();
  end
endmodule
